//--- src/rail_seq_regs.svh
// Register indices, field positions, reset values and timing counts of the rail sequencer
// Assumes a 100 MHz clock; byte address of a register is four times its index
// Function
// - Boost voltage select bits 7-6 pick 4.9, 5.0, 5.1 or 5.2 V.
// - Disabled boost connects discharge resistor only when bit 3 is set.
// - Pin-gate select 0 lets the enable bit alone control the boost.
// - Pin-gate select 1-3 ANDs the enable bit with input one, two, three.
// - Boost control bit 0 enables the boost, subject to pin gating.
// - Voltage, pin-gate, enable and delay defaults load from programmable memory.
// - First rail starts after code bits 3-0 times 0.5 ms from rising control.
// - First rail stops after code bits 7-4 times 0.5 ms from falling control.
// - Delay-scale bit set doubles every delay step to 1 ms.
// - Second rail starts after its own bits 3-0 delay from rising control.
// - Second rail stops after its own bits 7-4 delay from falling control.
// - Boost starts after boost timing bits 3-0 delay from rising control.
// - Boost stops after boost timing bits 7-4 delay from falling control.
`ifndef RAIL_SEQ_REGS_SVH
`define RAIL_SEQ_REGS_SVH
`define IDX_BOOST_CONTROL 6'h08
`define IDX_FIRST_DELAYS 6'h09
`define IDX_SECOND_DELAYS 6'h0a
`define IDX_BOOST_TIMING 6'h0b
`define IDX_SETUP 6'h10
`define IDX_STATUS 6'h11
`define RST_BOOST_CONTROL 8'h18
`define RST_DELAYS 8'h00
`define RST_SETUP 8'h00
`define BC_VSEL_MSB 7
`define BC_VSEL_LSB 6
`define BC_DISCHARGE_BIT 3
`define BC_GATE_MSB 2
`define BC_GATE_LSB 1
`define BC_ENABLE_BIT 0
`define DLY_ON_MSB 3
`define DLY_ON_LSB 0
`define DLY_OFF_MSB 7
`define DLY_OFF_LSB 4
`define SETUP_SCALE_BIT 0
`define CLK_PERIOD_NS 10
`define STEP_TIME_NS 500000
`define STEP_CYCLES (`STEP_TIME_NS / `CLK_PERIOD_NS)
`endif

//--- src/rail_seq_pkg.sv
// Types shared by the rail sequencer modules
// Assumes nothing beyond a SystemVerilog compiler
package rail_seq_pkg;
	typedef logic [23:0] delay_count_t;
	typedef enum logic [3:0] {
		RAIL_OFF = 4'b0001,
		RAIL_WAIT_ON = 4'b0010,
		RAIL_ON = 4'b0100,
		RAIL_WAIT_OFF = 4'b1000
	} rail_state_t;
	// Cycles of a delay code; scale doubles the step
	function automatic delay_count_t delay_target(input logic [3:0] code, input logic scale,
		input delay_count_t step);
		delay_count_t base;
		base = delay_count_t'(delay_count_t'(code) * step);
		return scale ? delay_count_t'({base, 1'b0}) : base;
	endfunction
endpackage

//--- src/rail_timer_if.sv
// Link between the register block and one rail delay timer
// Assumes both ends run on the same clock
interface rail_timer_if;
	logic ctrl;
	logic [3:0] on_code;
	logic [3:0] off_code;
	logic scale;
	logic rail_on;
	logic waiting;
	modport timer(input ctrl, on_code, off_code, scale, output rail_on, waiting);
	modport ctl(output ctrl, on_code, off_code, scale, input rail_on, waiting);
endinterface

//--- src/pin_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree
// Assumes asynchronous inputs and a synchronous active-high reset
module pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} sync_state_t;
	sync_state_t st_reg;
	sync_state_t st_next;
	always_comb begin
		st_next = st_reg;
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.q = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3) | ((st_reg.s2 ^ st_reg.s3) & st_reg.q);
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign q = st_reg.q;
endmodule

//--- src/rail_delay_timer.sv
// Startup and shutdown delay timer of one rail
// Assumes a control level from logic on the same clock
module rail_delay_timer #(
	parameter rail_seq_pkg::delay_count_t STEP = 24'h00c350
) (
	input wire logic clk,
	input wire logic rst,
	rail_timer_if.timer tif
);
	typedef struct packed {
		rail_seq_pkg::rail_state_t state;
		rail_seq_pkg::delay_count_t cnt;
		rail_seq_pkg::delay_count_t target;
		logic rail_on;
	} timer_state_t;
	timer_state_t st_reg;
	timer_state_t st_next;
	rail_seq_pkg::delay_count_t on_cycles;
	rail_seq_pkg::delay_count_t off_cycles;
	always_comb begin
		on_cycles = rail_seq_pkg::delay_target(tif.on_code, tif.scale, STEP);
		off_cycles = rail_seq_pkg::delay_target(tif.off_code, tif.scale, STEP);
		st_next = st_reg;
		case (st_reg.state)
			rail_seq_pkg::RAIL_OFF: begin
				// Rising control starts the startup delay
				if (tif.ctrl) begin
					st_next.cnt = 24'h000001;
					st_next.target = on_cycles;
					st_next.state = (on_cycles == '0) ? rail_seq_pkg::RAIL_ON :
						rail_seq_pkg::RAIL_WAIT_ON;
				end
			end
			rail_seq_pkg::RAIL_WAIT_ON: begin
				if (!tif.ctrl) begin
					st_next.state = rail_seq_pkg::RAIL_OFF;
				end else if (st_reg.cnt == st_reg.target) begin
					st_next.state = rail_seq_pkg::RAIL_ON;
				end else begin
					st_next.cnt = st_reg.cnt + 24'h000001;
				end
			end
			rail_seq_pkg::RAIL_ON: begin
				// Falling control starts the shutdown delay
				if (!tif.ctrl) begin
					st_next.cnt = 24'h000001;
					st_next.target = off_cycles;
					st_next.state = (off_cycles == '0) ? rail_seq_pkg::RAIL_OFF :
						rail_seq_pkg::RAIL_WAIT_OFF;
				end
			end
			rail_seq_pkg::RAIL_WAIT_OFF: begin
				if (tif.ctrl) begin
					st_next.state = rail_seq_pkg::RAIL_ON;
				end else if (st_reg.cnt == st_reg.target) begin
					st_next.state = rail_seq_pkg::RAIL_OFF;
				end else begin
					st_next.cnt = st_reg.cnt + 24'h000001;
				end
			end
			default: begin
				st_next.state = rail_seq_pkg::RAIL_OFF;
			end
		endcase
		st_next.rail_on = (st_next.state == rail_seq_pkg::RAIL_ON) ||
			(st_next.state == rail_seq_pkg::RAIL_WAIT_OFF);
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '{state: rail_seq_pkg::RAIL_OFF, cnt: '0, target: '0, rail_on: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end
	assign tif.rail_on = st_reg.rail_on;
	assign tif.waiting = (st_reg.state == rail_seq_pkg::RAIL_WAIT_ON) ||
		(st_reg.state == rail_seq_pkg::RAIL_WAIT_OFF);
endmodule

//--- src/rail_sequencer.sv
// Rail enable gating and delay sequencing with a classic Wishbone register slave
// Assumes a 100 MHz REF_CLK, synchronous SYS_RST, stable default inputs at reset release
`include "rail_seq_regs.svh"
module rail_sequencer #(
	parameter rail_seq_pkg::delay_count_t STEP_CYCLES = rail_seq_pkg::delay_count_t'(`STEP_CYCLES)
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic ENABLE_INPUT_ONE,
	input wire logic ENABLE_INPUT_TWO,
	input wire logic ENABLE_INPUT_THREE,
	input wire logic FIRST_STEP_DOWN_RAIL_CTRL,
	input wire logic SECOND_STEP_DOWN_RAIL_CTRL,
	input wire logic [7:0] OTP_BOOST_CONTROL,
	input wire logic [7:0] OTP_FIRST_DELAYS,
	input wire logic [7:0] OTP_SECOND_DELAYS,
	input wire logic [7:0] OTP_BOOST_TIMING,
	output logic BOOST_ON,
	output logic [1:0] BOOST_VOLTAGE_SELECT,
	output logic BOOST_DISCHARGE_SWITCH,
	output logic FIRST_STEP_DOWN_RAIL_ON,
	output logic SECOND_STEP_DOWN_RAIL_ON
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [7:0] boost_control;
		logic [7:0] first_delays;
		logic [7:0] second_delays;
		logic [7:0] boost_timing;
		logic [7:0] setup;
		logic loaded;
		logic ack;
		logic [31:0] rdata;
		logic discharge;
		logic [1:0] vsel;
	} seq_state_t;

	seq_state_t st_reg;
	seq_state_t st_next;

	localparam seq_state_t RESET_STATE = '{
		boost_control: `RST_BOOST_CONTROL,
		first_delays: `RST_DELAYS,
		second_delays: `RST_DELAYS,
		boost_timing: `RST_DELAYS,
		setup: `RST_SETUP,
		loaded: 1'b0,
		ack: 1'b0,
		rdata: 32'h00000000,
		discharge: 1'b0,
		vsel: 2'h0
	};

	// ************************************************************
	// Helper functions
	// ************************************************************
	// Enable bit gated by the selected external pin
	function automatic logic gated_enable(input logic enable, input logic [1:0] gate_sel,
		input logic [2:0] pins);
		logic result;
		result = 1'b0;
		case (gate_sel)
			2'h0: result = enable;
			2'h1: result = enable & pins[0];
			2'h2: result = enable & pins[1];
			2'h3: result = enable & pins[2];
			default: result = 1'b0;
		endcase
		return result;
	endfunction

	// Byte-lane 0 write merge for an eight-bit register
	function automatic logic [7:0] lane_write(input logic [7:0] old_value,
		input logic [31:0] wdata, input logic [3:0] sel);
		logic [7:0] result;
		result = sel[0] ? wdata[7:0] : old_value;
		return result;
	endfunction

	// Word index of a byte address; unaligned low bits are ignored
	function automatic logic [5:0] word_index(input logic [7:0] addr);
		logic [5:0] result;
		result = addr[7:2];
		return result;
	endfunction

	// Startup delay code of a sequence register
	function automatic logic [3:0] on_field(input logic [7:0] dly);
		logic [3:0] result;
		result = dly[`DLY_ON_MSB:`DLY_ON_LSB];
		return result;
	endfunction

	// Shutdown delay code of a sequence register
	function automatic logic [3:0] off_field(input logic [7:0] dly);
		logic [3:0] result;
		result = dly[`DLY_OFF_MSB:`DLY_OFF_LSB];
		return result;
	endfunction

	// Boost control after the default load; discharge and reserved bits keep reset
	function automatic logic [7:0] boost_default(input logic [7:0] current,
		input logic [7:0] otp);
		logic [7:0] result;
		result = current;
		result[`BC_VSEL_MSB:`BC_VSEL_LSB] = otp[`BC_VSEL_MSB:`BC_VSEL_LSB];
		result[`BC_GATE_MSB:`BC_GATE_LSB] = otp[`BC_GATE_MSB:`BC_GATE_LSB];
		result[`BC_ENABLE_BIT] = otp[`BC_ENABLE_BIT];
		return result;
	endfunction

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [2:0] pins_raw;
	logic [2:0] pins_sync;

	assign pins_raw = {ENABLE_INPUT_THREE, ENABLE_INPUT_TWO, ENABLE_INPUT_ONE};

	pin_sync #(
		.WIDTH(3)
	) u_pin_sync (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.d(pins_raw),
		.q(pins_sync)
	);

	// ************************************************************
	// Rail timers
	// ************************************************************
	rail_timer_if boost_tif ();
	rail_timer_if first_tif ();
	rail_timer_if second_tif ();

	logic boost_ctrl_level;
	logic scale;
	logic boost_enable_bit;
	logic [1:0] boost_gate_sel;
	logic boost_discharge_bit;
	logic [1:0] boost_vsel_field;

	assign scale = st_reg.setup[`SETUP_SCALE_BIT];
	assign boost_enable_bit = st_reg.boost_control[`BC_ENABLE_BIT];
	assign boost_gate_sel = st_reg.boost_control[`BC_GATE_MSB:`BC_GATE_LSB];
	assign boost_discharge_bit = st_reg.boost_control[`BC_DISCHARGE_BIT];
	assign boost_vsel_field = st_reg.boost_control[`BC_VSEL_MSB:`BC_VSEL_LSB];

	// Boost control level from enable bit and pin gate
	assign boost_ctrl_level = gated_enable(boost_enable_bit, boost_gate_sel,
		pins_sync);

	assign boost_tif.ctrl = boost_ctrl_level;
	assign boost_tif.on_code = on_field(st_reg.boost_timing);
	assign boost_tif.off_code = off_field(st_reg.boost_timing);
	assign boost_tif.scale = scale;

	assign first_tif.ctrl = FIRST_STEP_DOWN_RAIL_CTRL;
	assign first_tif.on_code = on_field(st_reg.first_delays);
	assign first_tif.off_code = off_field(st_reg.first_delays);
	assign first_tif.scale = scale;

	assign second_tif.ctrl = SECOND_STEP_DOWN_RAIL_CTRL;
	assign second_tif.on_code = on_field(st_reg.second_delays);
	assign second_tif.off_code = off_field(st_reg.second_delays);
	assign second_tif.scale = scale;

	rail_delay_timer #(
		.STEP(STEP_CYCLES)
	) u_boost_timer (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.tif(boost_tif.timer)
	);

	rail_delay_timer #(
		.STEP(STEP_CYCLES)
	) u_first_timer (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.tif(first_tif.timer)
	);

	rail_delay_timer #(
		.STEP(STEP_CYCLES)
	) u_second_timer (
		.clk(REF_CLK),
		.rst(SYS_RST),
		.tif(second_tif.timer)
	);

	// ************************************************************
	// Status word
	// ************************************************************
	typedef struct packed {
		logic [20:0] spare;
		logic [2:0] pins;
		logic boost_ctrl;
		logic second_waiting;
		logic first_waiting;
		logic boost_waiting;
		logic discharge;
		logic second_on;
		logic first_on;
		logic boost_on;
	} status_t;

	status_t status_word;

	assign status_word = '{
		spare: 21'h000000,
		pins: pins_sync,
		boost_ctrl: boost_ctrl_level,
		second_waiting: second_tif.waiting,
		first_waiting: first_tif.waiting,
		boost_waiting: boost_tif.waiting,
		discharge: st_reg.discharge,
		second_on: second_tif.rail_on,
		first_on: first_tif.rail_on,
		boost_on: boost_tif.rail_on
	};

	// ************************************************************
	// Register access
	// ************************************************************
	logic request;
	logic [5:0] index;
	logic [31:0] read_word;

	assign request = WB_CYC_I & WB_STB_I & ~st_reg.ack & st_reg.loaded;
	assign index = word_index(WB_ADR_I);

	// Read mux; unmapped indices read zero
	always_comb begin
		read_word = 32'h00000000;
		case (index)
			`IDX_BOOST_CONTROL: begin
				read_word = {24'h000000, st_reg.boost_control};
			end
			`IDX_FIRST_DELAYS: begin
				read_word = {24'h000000, st_reg.first_delays};
			end
			`IDX_SECOND_DELAYS: begin
				read_word = {24'h000000, st_reg.second_delays};
			end
			`IDX_BOOST_TIMING: begin
				read_word = {24'h000000, st_reg.boost_timing};
			end
			`IDX_SETUP: begin
				read_word = {24'h000000, st_reg.setup};
			end
			`IDX_STATUS: begin
				read_word = status_word;
			end
			default: begin
				read_word = 32'h00000000;
			end
		endcase
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.ack = request;

		// Defaults come in once, in the first cycle after reset
		if (!st_reg.loaded) begin
			st_next.loaded = 1'b1;
			st_next.boost_control = boost_default(st_reg.boost_control,
				OTP_BOOST_CONTROL);
			st_next.first_delays = OTP_FIRST_DELAYS;
			st_next.second_delays = OTP_SECOND_DELAYS;
			st_next.boost_timing = OTP_BOOST_TIMING;
		end

		// Write takes effect at the edge that raises ack
		if (request && WB_WE_I) begin
			case (index)
				`IDX_BOOST_CONTROL: begin
					st_next.boost_control = lane_write(st_reg.boost_control, WB_DAT_I, WB_SEL_I);
				end
				`IDX_FIRST_DELAYS: begin
					st_next.first_delays = lane_write(st_reg.first_delays, WB_DAT_I, WB_SEL_I);
				end
				`IDX_SECOND_DELAYS: begin
					st_next.second_delays = lane_write(st_reg.second_delays, WB_DAT_I, WB_SEL_I);
				end
				`IDX_BOOST_TIMING: begin
					st_next.boost_timing = lane_write(st_reg.boost_timing, WB_DAT_I, WB_SEL_I);
				end
				`IDX_SETUP: begin
					st_next.setup = lane_write(st_reg.setup, WB_DAT_I, WB_SEL_I);
				end
				default: begin
					st_next.setup = st_reg.setup;
				end
			endcase
		end

		if (request && !WB_WE_I) begin
			st_next.rdata = read_word;
		end

		// Discharge path only while the registered boost output is off, so it follows the boost one cycle late
		st_next.discharge = ~boost_tif.rail_on & boost_discharge_bit;
		st_next.vsel = boost_vsel_field;
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			st_reg <= RESET_STATE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign WB_ACK_O = st_reg.ack;
	assign WB_DAT_O = st_reg.rdata;
	assign BOOST_ON = boost_tif.rail_on;
	assign BOOST_VOLTAGE_SELECT = st_reg.vsel;
	assign BOOST_DISCHARGE_SWITCH = st_reg.discharge;
	assign FIRST_STEP_DOWN_RAIL_ON = first_tif.rail_on;
	assign SECOND_STEP_DOWN_RAIL_ON = second_tif.rail_on;
endmodule

//--- tb/rail_sequencer_checker.sv
// Concurrent checks on the rail sequencer ports
// Assumes REF_CLK with synchronous active-high SYS_RST
module rail_sequencer_checker (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic WB_ACK_O,
	input wire logic FIRST_STEP_DOWN_RAIL_CTRL,
	input wire logic SECOND_STEP_DOWN_RAIL_CTRL,
	input wire logic BOOST_ON,
	input wire logic [1:0] BOOST_VOLTAGE_SELECT,
	input wire logic BOOST_DISCHARGE_SWITCH,
	input wire logic FIRST_STEP_DOWN_RAIL_ON,
	input wire logic SECOND_STEP_DOWN_RAIL_ON
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Checks
	// ****
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	sequence ctl_write_s;
		WB_ACK_O && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == 8'h20;
	endsequence
	sequence req_gone_s;
		!$past(WB_CYC_I) || !$past(WB_STB_I);
	endsequence
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (WB_ACK_O |-> not req_gone_s)
		else $error("ack without request");
	a_vsel_write: assert property (ctl_write_s |=> BOOST_VOLTAGE_SELECT == $past(WB_DAT_I[7:6]))
		else $error("voltage select not updated");
	a_discharge_off: assert property (BOOST_ON && $past(BOOST_ON) |-> !BOOST_DISCHARGE_SWITCH)
		else $error("discharge while boost on");
	a_first_rise: assert property ($rose(FIRST_STEP_DOWN_RAIL_ON) |-> $past(FIRST_STEP_DOWN_RAIL_CTRL))
		else $error("first rail on without control");
	a_first_fall: assert property ($fell(FIRST_STEP_DOWN_RAIL_ON) && !$past(SYS_RST)
		|-> !$past(FIRST_STEP_DOWN_RAIL_CTRL))
		else $error("first rail off with control high");
	a_second_rise: assert property ($rose(SECOND_STEP_DOWN_RAIL_ON) |-> $past(SECOND_STEP_DOWN_RAIL_CTRL))
		else $error("second rail on without control");
	a_second_fall: assert property ($fell(SECOND_STEP_DOWN_RAIL_ON) && !$past(SYS_RST)
		|-> !$past(SECOND_STEP_DOWN_RAIL_CTRL))
		else $error("second rail off with control high");
	a_reset_quiet: assert property (disable iff (1'b0) SYS_RST |=> !WB_ACK_O && !BOOST_ON
		&& !FIRST_STEP_DOWN_RAIL_ON && !SECOND_STEP_DOWN_RAIL_ON)
		else $error("outputs active in reset");
endmodule

bind rail_sequencer rail_sequencer_checker i_rail_sequencer_checker (.REF_CLK(REF_CLK),
	.SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
	.WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O),
	.FIRST_STEP_DOWN_RAIL_CTRL(FIRST_STEP_DOWN_RAIL_CTRL), .BOOST_ON(BOOST_ON),
	.SECOND_STEP_DOWN_RAIL_CTRL(SECOND_STEP_DOWN_RAIL_CTRL),
	.BOOST_VOLTAGE_SELECT(BOOST_VOLTAGE_SELECT), .BOOST_DISCHARGE_SWITCH(BOOST_DISCHARGE_SWITCH),
	.FIRST_STEP_DOWN_RAIL_ON(FIRST_STEP_DOWN_RAIL_ON),
	.SECOND_STEP_DOWN_RAIL_ON(SECOND_STEP_DOWN_RAIL_ON));

//--- tb/rail_sequencer_bench.sv
// Self-checking bench of the rail sequencer
// Assumes STEP_CYCLES of 4 and a 100 MHz clock
module rail_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Stimulus and checks
	// ****
	localparam int STEP = 4;
	// Boost count starts two edges late: its control rides on a bus write
	localparam int WB_LAT = 2;
	typedef struct packed {logic [7:0] bc; logic [2:0] pins; logic on; logic dis;
		logic [1:0] vs;} row_t;
	typedef struct {int r; logic [3:0] on; logic [3:0] off; logic sc;} trow_t;
	logic ref_clk, sys_rst, cyc, stb, we, ack, b_on, dis, f_on, s_on, f_ctrl, s_ctrl;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, dout;
	logic [2:0] pins;
	logic [1:0] vsel;
	int bad_count = 0, cmp_count = 0, cyc_count = 0, k, m, lat, base[2];
	wire [2:0] rail_on = {b_on, s_on, f_on};
	row_t rows [10] = '{'{8'h19, 3'h0, 1'b1, 1'b0, 2'h0}, '{8'h5b, 3'h1, 1'b1, 1'b0, 2'h1},
		'{8'h5b, 3'h6, 1'b0, 1'b1, 2'h1}, '{8'h95, 3'h2, 1'b1, 1'b0, 2'h2},
		'{8'h95, 3'h5, 1'b0, 1'b0, 2'h2}, '{8'hdf, 3'h4, 1'b1, 1'b0, 2'h3},
		'{8'hdf, 3'h3, 1'b0, 1'b1, 2'h3}, '{8'hd8, 3'h7, 1'b0, 1'b1, 2'h3},
		'{8'h11, 3'h0, 1'b1, 1'b0, 2'h0}, '{8'h10, 3'h7, 1'b0, 1'b0, 2'h0}};
	trow_t trows [6] = '{'{0, 4'h1, 4'hf, 1'b0}, '{1, 4'hf, 4'h3, 1'b1}, '{2, 4'h7, 4'h1, 1'b0},
		'{0, 4'h0, 4'h2, 1'b1}, '{2, 4'hf, 4'hf, 1'b1}, '{1, 4'h5, 4'h0, 1'b0}};
	rail_sequencer #(.STEP_CYCLES(24'h000004)) i_rail_sequencer (.REF_CLK(ref_clk),
		.SYS_RST(sys_rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.ENABLE_INPUT_ONE(pins[0]), .ENABLE_INPUT_TWO(pins[1]), .ENABLE_INPUT_THREE(pins[2]),
		.FIRST_STEP_DOWN_RAIL_CTRL(f_ctrl), .SECOND_STEP_DOWN_RAIL_CTRL(s_ctrl),
		.OTP_BOOST_CONTROL(8'he6), .OTP_FIRST_DELAYS(8'h21), .OTP_SECOND_DELAYS(8'h43),
		.OTP_BOOST_TIMING(8'h65), .BOOST_ON(b_on), .BOOST_VOLTAGE_SELECT(vsel),
		.BOOST_DISCHARGE_SWITCH(dis), .FIRST_STEP_DOWN_RAIL_ON(f_on),
		.SECOND_STEP_DOWN_RAIL_ON(s_on));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc_count <= cyc_count + 1;
		if (cyc_count == 20000) begin
			bad_count = bad_count + 1;
			print_verdict();
		end
	end
	task automatic print_verdict();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do @(posedge ref_clk); while (ack !== 1'b1);
		dout = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 8'h00);
		check(dout, e);
	endtask
	// Cycles from the stimulus edge until the rail output reaches v
	task automatic meas(input int r, input logic v, output int n);
		@(posedge ref_clk);
		if (r == 0) f_ctrl <= v;
		else if (r == 1) s_ctrl <= v;
		else wb(1'b1, 8'h20, {7'h0c, v});
		n = 0;
		@(posedge ref_clk);
		#1;
		while (rail_on[r] !== v && n < 300) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
	endtask
	initial begin
		sys_rst = 1'b1;
		{cyc, stb, we, f_ctrl, s_ctrl} = 5'h00;
		{adr, wdat, pins, sel} = {8'h00, 32'h0, 3'h0, 4'h1};
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(8'h20, 32'hde);
		rd(8'h24, 32'h21);
		rd(8'h28, 32'h43);
		rd(8'h2c, 32'h65);
		rd(8'h40, 32'h00);
		check({30'h0, vsel, dis}, 32'h7);
		wb(1'b1, 8'h30, 8'hff);
		rd(8'h30, 32'h00);
		sel <= 4'h0;
		wb(1'b1, 8'h24, 8'hff);
		sel <= 4'h1;
		rd(8'h24, 32'h21);
		wb(1'b1, 8'h2c, 8'h00);
		foreach (rows[i]) begin
			pins <= rows[i].pins;
			wb(1'b1, 8'h20, rows[i].bc);
			repeat (8) @(posedge ref_clk);
			#1 check({29'h0, b_on, vsel}, {29'h0, rows[i].on, rows[i].vs});
			check({31'h0, dis}, {31'h0, rows[i].dis});
			rd(8'h20, {24'h0, rows[i].bc});
		end
		rd(8'h44, 32'h700);
		meas(2, 1'b1, base[1]);
		check(32'(base[1]), 32'h0);
		meas(2, 1'b0, base[0]);
		check(32'(base[0]), 32'h0);
		foreach (trows[i]) begin
			wb(1'b1, 8'h40, {7'h0, trows[i].sc});
			wb(1'b1, 8'h24 + 8'(4 * trows[i].r), {trows[i].off, trows[i].on});
			m = trows[i].sc ? 2 * STEP : STEP;
			lat = (trows[i].r == 2) ? WB_LAT : 0;
			meas(trows[i].r, 1'b1, k);
			check(32'(k), 32'(trows[i].on * m - lat));
			meas(trows[i].r, 1'b0, k);
			check(32'(k), 32'(trows[i].off * m - lat));
		end
		wb(1'b1, 8'h40, 8'h00);
		wb(1'b1, 8'h24, 8'h03);
		f_ctrl <= 1'b1;
		for (int i = 0; i < 30; i++) begin
			@(posedge ref_clk);
			if (i == 6) f_ctrl <= 1'b0;
			#1 check({31'h0, f_on}, 32'h0);
		end
		print_verdict();
	end
endmodule
